// >>> hw/msd_stall_top.sv
// Stall detection and positioning sequencer with an AHB-Lite register slave.
//
// Overview of operation
// - First status query reports faults and releases the shutdown state.
// - Reference search whose first target equals position enters deadlock.
// - Reference search runs two motions, then clears position to zero; a stall halting the second motion leaves it uncleared.
// - Combined stall is OR of delta-low, delta-high and absolute flags.
// - Delta-low set when back voltage below average minus delta.
// - Delta-high set when back voltage above average plus delta.
// - Absolute flag set when back voltage below absolute level.
// - A stall that halts the motor also sets lost step.
// - Delay code selects 87..391 us, halved at fast chopper rate.
// - After acceleration, evaluation is blanked for 0..7 full steps.
// - Absolute code zero disables; else level is code times 0.5 V.
// - Delta code zero disables; else delta is code times 0.25 V.
// - Full-duty mask suppresses detection while duty is 100%.
// - Target move ignored on thermal, undervoltage, lost step or coil fault.
// - Detection word holds frame bytes 6, 7 and 8 field layout.
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module msd_stall_top import msd_pkg::*; #(
	parameter int unsigned BW     = 8,
	parameter int unsigned CYC_US = CYC_PER_US
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	// Motor side inputs
	input  wire logic          step_tick,
	input  wire logic          accel_active,
	input  wire logic          duty_full,
	input  wire logic [BW-1:0] back_voltage,
	input  wire logic [BW-1:0] averaged_back_voltage,
	input  wire logic          thermal_shutdown_flag,
	input  wire logic          undervoltage_flag,
	input  wire logic          coil_fault_flag,
	// Motor side outputs
	output logic               step_pulse,
	output logic               step_dir,
	output logic               motion_busy,
	output logic               stall_out
);

	logic [31:0] det_r, mot_r, hrdata_r;
	logic [7:0]  waddr_r;
	logic        wpend_r, params_r, shut_r, hready_r, hresp_r;
	logic        dlo_r, dhi_r, abs_r, lost_r, stall_r;
	logic        step_r, dir_r, busy_r;
	logic [15:0] pos_r, tgt_r, ref2_r;
	logic [15:0] pos_nxt, tgt_nxt, ref2_nxt;
	msd_mot_e    state_r, state_nxt;
	msd_hits_s   hits;

	// ==========================================================
	// Bus decode. Zero wait states; hsize is accepted as a whole word.
	wire logic       acc     = hsel & hready & htrans[1];
	wire logic [7:0] aofs    = haddr[7:0];
	wire logic       rd_acc  = acc & ~hwrite;
	wire logic       rd_st1  = rd_acc & (aofs == OFS_STAT1); // status_query_first
	wire logic       wr_det  = wpend_r & (waddr_r == OFS_DET);
	wire logic       wr_mot  = wpend_r & (waddr_r == OFS_MOTOR);
	wire logic       cmd_mv  = wpend_r & (waddr_r == OFS_TARGET);
	wire logic       cmd_ref = wpend_r & (waddr_r == OFS_REF);

	// Detection fields unpacked from the frame-shaped word.
	wire msd_cfg_s cfg = '{dly: det_r[DET_DLY_LSB +: 3], rate: mot_r[MOT_RATE_BIT],
		abs_thr: det_r[DET_ABS_LSB +: 4], del_thr: det_r[DET_DEL_LSB +: 4],
		blank: det_r[DET_BLK_LSB +: 3], duty_mask: det_r[DET_MASK_BIT]};

	// ==========================================================
	// Sticky flags: a hit in the clearing cycle wins over the clear.
	wire logic moving   = (state_r == MS_MOVE) | (state_r == MS_REF1) | (state_r == MS_REF2);
	wire logic any_hit  = hits.lo | hits.hi | hits.ab;
	wire logic halt     = moving & any_hit;
	wire logic dlo_nxt  = hits.lo | (dlo_r & ~rd_st1);
	wire logic dhi_nxt  = hits.hi | (dhi_r & ~rd_st1);
	wire logic abs_nxt  = hits.ab | (abs_r & ~rd_st1);
	wire logic lost_nxt = halt | (lost_r & ~rd_st1);
	wire logic stl_nxt  = dlo_nxt | dhi_nxt | abs_nxt;
	wire logic fault    = thermal_shutdown_flag | undervoltage_flag | lost_r | coil_fault_flag;

	wire logic [31:0] st1_word = {21'h0, busy_r, state_r == MS_LOCK, shut_r, coil_fault_flag,
		undervoltage_flag, thermal_shutdown_flag, lost_r, stall_r, abs_r, dhi_r, dlo_r};

	// Read mux; unmapped offsets read as zero.
	wire logic [31:0] rd_mux = (aofs == OFS_DET)    ? det_r :
		(aofs == OFS_MOTOR)  ? mot_r :
		(aofs == OFS_STAT1)  ? st1_word :
		(aofs == OFS_POS)    ? {16'h0, pos_r} :
		(aofs == OFS_TARGET) ? {16'h0, tgt_r} : 32'h0;

	// Commands are accepted only when the device is out of shutdown and configured.
	wire logic ready    = ~shut_r & params_r & (state_r == MS_IDLE);
	wire logic move_ok  = cmd_mv & ready & ~fault;
	wire logic ref_ok   = cmd_ref & ready;
	wire logic ref_dead = ref_ok & (hwdata[31:16] == pos_r);
	wire logic at_tgt   = (pos_r == tgt_r);
	wire logic step_nxt = moving & step_tick & ~at_tgt & ~halt;

	// ==========================================================
	// Motion sequencer next state.
	always_comb begin
		state_nxt = state_r;
		pos_nxt   = pos_r;
		tgt_nxt   = tgt_r;
		ref2_nxt  = ref2_r;
		unique case (state_r)
			MS_IDLE: begin
				if (move_ok) begin
					tgt_nxt   = hwdata[15:0];
					state_nxt = MS_MOVE;
				end else if (ref_dead) begin
					state_nxt = MS_LOCK;
				end else if (ref_ok) begin
					tgt_nxt   = hwdata[31:16];
					ref2_nxt  = hwdata[15:0];
					state_nxt = MS_REF1;
				end
			end
			MS_MOVE, MS_REF2: begin
				if (halt) begin
					state_nxt = MS_IDLE;
				end else if (at_tgt) begin
					state_nxt = MS_IDLE;
					if (state_r == MS_REF2) begin
						pos_nxt = 16'h0;
					end
				end else if (step_tick) begin
					pos_nxt = (tgt_r > pos_r) ? pos_r + 16'h1 : pos_r - 16'h1;
				end
			end
			MS_REF1: begin
				// Running into the stop ends the first motion either way.
				if (halt || at_tgt) begin
					tgt_nxt   = ref2_r;
					state_nxt = MS_REF2;
				end else if (step_tick) begin
					pos_nxt = (tgt_r > pos_r) ? pos_r + 16'h1 : pos_r - 16'h1;
				end
			end
			MS_LOCK: begin
				// Deadlock is left only through reset.
				state_nxt = MS_LOCK;
			end
		endcase
	end

	// ==========================================================
	// Bus slave registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hready_r <= 1'b1;
			hresp_r  <= 1'b0;
			hrdata_r <= 32'h0;
			wpend_r  <= 1'b0;
			waddr_r  <= 8'h0;
		end else begin
			hready_r <= 1'b1;
			hresp_r  <= 1'b0;
			hrdata_r <= rd_acc ? rd_mux : 32'h0;
			wpend_r  <= acc & hwrite;
			waddr_r  <= aofs;
		end
	end

	// Configuration words and the parameters-written marker.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			det_r    <= DET_RST;
			mot_r    <= MOT_RST;
			params_r <= 1'b0;
		end else begin
			if (wr_det) det_r <= hwdata;
			if (wr_mot) mot_r <= hwdata;
			if (wr_mot) params_r <= 1'b1;
		end
	end

	// Shutdown is left on the first status query after reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shut_r <= 1'b1;
		end else if (rd_st1) begin
			shut_r <= 1'b0;
		end
	end

	// Flags, combined stall and the motion state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{dlo_r, dhi_r, abs_r, lost_r, stall_r} <= 5'h0;
			state_r <= MS_IDLE;
			{pos_r, tgt_r, ref2_r} <= 48'h0;
			{step_r, dir_r, busy_r} <= 3'h0;
		end else begin
			{dlo_r, dhi_r, abs_r, lost_r} <= {dlo_nxt, dhi_nxt, abs_nxt, lost_nxt};
			stall_r <= stl_nxt;
			state_r <= state_nxt;
			{pos_r, tgt_r, ref2_r} <= {pos_nxt, tgt_nxt, ref2_nxt};
			step_r  <= step_nxt;
			dir_r   <= (tgt_r > pos_r);
			busy_r  <= (state_nxt != MS_IDLE) & (state_nxt != MS_LOCK);
		end
	end

	msd_stall_eval #(
		.BW     (BW),
		.CW     (16),
		.CYC_US (CYC_US)
	) u_eval (
		.hclk                  (hclk),
		.hresetn               (hresetn),
		.cfg                   (cfg),
		.enable                (moving),
		.full_step             (step_r),
		.accel_active          (accel_active),
		.duty_full             (duty_full),
		.back_voltage          (back_voltage),
		.averaged_back_voltage (averaged_back_voltage),
		.hits                  (hits)
	);

	assign hreadyout   = hready_r;
	assign hresp       = hresp_r;
	assign hrdata      = hrdata_r;
	assign step_pulse  = step_r;
	assign step_dir    = dir_r;
	assign motion_busy = busy_r;
	assign stall_out   = stall_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	stall_or_a: assert property (stall_r == (dlo_r | dhi_r | abs_r))
		else $error("combined stall differs from flag OR");
	dlo_set_a: assert property (hits.lo |=> dlo_r && stall_out)
		else $error("delta-low hit lost");
	dhi_set_a: assert property (hits.hi |=> dhi_r && stall_out)
		else $error("delta-high hit lost");
	abs_set_a: assert property (hits.ab |=> abs_r && stall_out)
		else $error("absolute hit lost");
	lost_step_a: assert property (halt |=> lost_r && state_r != MS_MOVE)
		else $error("stall halt without lost step");
	flag_hold_a: assert property (dlo_r && !rd_st1 |=> dlo_r)
		else $error("delta-low dropped before report");
	shut_leave_a: assert property (rd_st1 |=> !shut_r ##1 !shut_r)
		else $error("shutdown not left after status query");
	ref_zero_a: assert property (state_r == MS_REF2 && at_tgt && !halt
		|=> pos_r == 16'h0 && state_r == MS_IDLE)
		else $error("position not cleared after reference search");
	move_block_a: assert property (cmd_mv && fault && state_r == MS_IDLE |=> state_r != MS_MOVE)
		else $error("target move taken despite fault");
	dead_lock_a: assert property (ref_dead |=> state_r == MS_LOCK [*2])
		else $error("deadlock not entered");
	det_field_a: assert property (wr_det |=> cfg.dly == $past(hwdata[23:21])
		&& cfg.abs_thr == $past(hwdata[15:12]))
		else $error("detection fields misplaced");

	ref_run_c: cover property (state_r == MS_REF1 ##[1:1000] state_r == MS_REF2
		##[1:1000] state_r == MS_IDLE);
	stall_halt_c: cover property (state_r == MS_MOVE && halt);
	flag_clear_c: cover property (dlo_r ##1 rd_st1 ##1 !dlo_r);

endmodule : msd_stall_top

// >>> hw/msd_pkg.sv
// Shared constants, field layouts and types of the stall detection block.
package msd_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ     = 20_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_DET    = 8'h00;
	localparam logic [7:0] OFS_MOTOR  = 8'h04;
	localparam logic [7:0] OFS_STAT1  = 8'h08;
	localparam logic [7:0] OFS_POS    = 8'h0c;
	localparam logic [7:0] OFS_TARGET = 8'h10;
	localparam logic [7:0] OFS_REF    = 8'h14;

	// ==========================================================
	// Detection word: bits 23:16 frame byte 6, 15:8 byte 7, 7:0 byte 8.
	localparam int unsigned DET_DLY_LSB  = 21;
	localparam int unsigned DET_ABS_LSB  = 12;
	localparam int unsigned DET_DEL_LSB  = 8;
	localparam int unsigned DET_BLK_LSB  = 5;
	localparam int unsigned DET_MASK_BIT = 1;
	localparam int unsigned MOT_RATE_BIT = 6;
	localparam logic [31:0] DET_RST      = 32'h0000_0000;
	localparam logic [31:0] MOT_RST      = 32'h0000_0000;

	// Status word bit positions.
	localparam int unsigned ST_DLO  = 0;
	localparam int unsigned ST_DHI  = 1;
	localparam int unsigned ST_ABS  = 2;
	localparam int unsigned ST_STL  = 3;
	localparam int unsigned ST_LOST = 4;
	localparam int unsigned ST_TSD  = 5;
	localparam int unsigned ST_UV   = 6;
	localparam int unsigned ST_COIL = 7;
	localparam int unsigned ST_SHUT = 8;
	localparam int unsigned ST_LOCK = 9;
	localparam int unsigned ST_BUSY = 10;

	// ==========================================================
	// Sample delay in microseconds, indexed by the 3-bit code.
	localparam logic [7:0][8:0] DLY_US_R0 = {9'd391, 9'd348, 9'd304, 9'd261,
		9'd217, 9'd174, 9'd130, 9'd87};
	localparam logic [7:0][8:0] DLY_US_R1 = {9'd196, 9'd174, 9'd152, 9'd130,
		9'd109, 9'd87, 9'd65, 9'd43};

	// Voltage units are 0.25 V; an absolute code step is two units, a delta code step one.
	localparam int unsigned ABS_UNITS = 2;
	localparam int unsigned DEL_UNITS = 1;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [2:0] dly;
		logic       rate;
		logic [3:0] abs_thr;
		logic [3:0] del_thr;
		logic [2:0] blank;
		logic       duty_mask;
	} msd_cfg_s;

	typedef struct packed {
		logic lo;
		logic hi;
		logic ab;
	} msd_hits_s;

	typedef enum logic [2:0] {MS_IDLE, MS_MOVE, MS_REF1, MS_REF2, MS_LOCK} msd_mot_e;

endpackage : msd_pkg

// >>> hw/msd_stall_eval.sv
// Back-voltage sampling timer, blanking and threshold comparison.
`timescale 1ns/1ps
module msd_stall_eval import msd_pkg::*; #(
	parameter int unsigned BW     = 8,
	parameter int unsigned CW     = 16,
	parameter int unsigned CYC_US = CYC_PER_US
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Configuration and motion context
	input  wire msd_cfg_s      cfg,
	input  wire logic          enable,
	input  wire logic          full_step,
	input  wire logic          accel_active,
	input  wire logic          duty_full,
	// Measurements
	input  wire logic [BW-1:0] back_voltage,
	input  wire logic [BW-1:0] averaged_back_voltage,
	// Result pulses
	output msd_hits_s          hits
);

	logic [CW-1:0] timer_r;
	logic [2:0]    blank_r;
	logic          accel_d_r;
	msd_hits_s     hits_r;

	// ==========================================================
	// Delay selection, halved table at the fast chopper rate.
	wire logic [8:0]    dly_us  = cfg.rate ? DLY_US_R1[cfg.dly] : DLY_US_R0[cfg.dly];
	wire logic [CW-1:0] dly_cyc = CW'(dly_us * CYC_US);
	wire logic          sample  = (timer_r == CW'(1));
	wire logic          accel_end = accel_d_r & ~accel_active;

	// Blanking and duty masking gate the evaluation.
	wire logic eval_ok = sample & enable & (blank_r == 3'h0)
		& ~(cfg.duty_mask & duty_full);

	// Comparisons are one bit wider so that sums never wrap.
	wire logic [BW:0] bv   = {1'b0, back_voltage};
	wire logic [BW:0] avg  = {1'b0, averaged_back_voltage};
	wire logic [BW:0] dlt  = (BW+1)'(cfg.del_thr * DEL_UNITS);
	wire logic [BW:0] absl = (BW+1)'(cfg.abs_thr * ABS_UNITS);
	wire logic        lo_c = (bv + dlt) < avg;
	wire logic        hi_c = bv > (avg + dlt);
	wire logic        ab_c = bv < absl;
	wire logic        del_on = (cfg.del_thr != 4'h0);
	wire logic        abs_on = (cfg.abs_thr != 4'h0);

	// Delay timer restarts on every full step; at most one sample per step.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_r <= '0;
		end else if (full_step) begin
			timer_r <= dly_cyc;
		end else if (timer_r != '0) begin
			timer_r <= timer_r - CW'(1);
		end
	end

	// Blanking counter loaded when an acceleration phase ends.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blank_r   <= 3'h0;
			accel_d_r <= 1'b0;
		end else begin
			accel_d_r <= accel_active;
			if (accel_end) begin
				blank_r <= cfg.blank;
			end else if (full_step && blank_r != 3'h0) begin
				blank_r <= blank_r - 3'h1;
			end
		end
	end

	// One-cycle hit pulses.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hits_r <= '0;
		end else begin
			hits_r <= '{lo: eval_ok & del_on & lo_c, hi: eval_ok & del_on & hi_c,
				ab: eval_ok & abs_on & ab_c};
		end
	end
	assign hits = hits_r;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	delay_load_a: assert property (full_step |=> timer_r == $past(dly_cyc))
		else $error("sample delay not loaded");
	blank_gate_a: assert property (hits != 3'h0 |-> $past(blank_r) == 3'h0)
		else $error("hit during blanking");
	duty_mask_a: assert property (hits != 3'h0 |-> !$past(cfg.duty_mask && duty_full))
		else $error("hit at full duty while masked");
	abs_off_a: assert property (hits.ab |-> $past(cfg.abs_thr) != 4'h0)
		else $error("absolute hit while disabled");
	del_off_a: assert property ((hits.lo || hits.hi) |-> $past(cfg.del_thr) != 4'h0)
		else $error("delta hit while disabled");

endmodule : msd_stall_eval

// >>> verif/msd_motor_model.sv
// Motor side model: step opportunities and back-voltage levels for the bench.
`timescale 1ns/1ps
module msd_motor_model import msd_pkg::*; #(
	parameter int unsigned BW     = 8,
	parameter int unsigned PERIOD = 100
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Levels requested by the bench
	input  wire logic [BW-1:0] bv_set,
	input  wire logic [BW-1:0] av_set,
	// Motor side outputs
	output logic               step_tick,
	output logic [BW-1:0]      back_voltage,
	output logic [BW-1:0]      averaged_back_voltage
);
	logic [15:0] cnt_r;

	// ==========================================================
	// Step opportunities
	// The period is longer than the shorter sample delays only, so at those codes a sample lands in every step.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r     <= 16'h0000;
			step_tick <= 1'b0;
		end else begin
			cnt_r     <= (cnt_r == 16'(PERIOD - 1)) ? 16'h0000 : cnt_r + 16'h0001;
			step_tick <= (cnt_r == 16'h0000);
		end
	end

	// ==========================================================
	// Back voltage
	// Levels move on the clock edge, like a converter result register would.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			back_voltage          <= '0;
			averaged_back_voltage <= '0;
		end else begin
			back_voltage          <= bv_set;
			averaged_back_voltage <= av_set;
		end
	end
endmodule : msd_motor_model

// >>> verif/msd_stall_top_bench.sv
// Self-checking bench that plays the host over AHB-Lite against the stall block.
`timescale 1ns/1ps
module msd_stall_top_bench import msd_pkg::*;;
	localparam int NC = 9;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        step_tick, duty_full, thermal, step_pulse, step_dir, motion_busy, stall_out;
	logic        uv, coil, accel;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [7:0]  bv, av, back_voltage, averaged_back_voltage;
	int          bad_count, comparisons, n_steps, n_up;
	// Case table: detection word, measured level, duty state, expected sticky bits.
	logic [31:0] c_det [NC] = '{32'h200, 32'h200, 32'h200, 32'h200, 32'h200, 32'h0,
		32'h2000, 32'h2000, 32'h202};
	logic [7:0]  c_back [NC] = '{8'h28, 8'h25, 8'h26, 8'h2b, 8'h2a, 8'h14, 8'h03, 8'h04, 8'h25};
	logic        c_duty [NC] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
	logic [4:0]  c_exp [NC] = '{5'h00, 5'h19, 5'h00, 5'h1a, 5'h00, 5'h00, 5'h1c, 5'h00, 5'h00};

	// ==========================================================
	// Instances
	msd_stall_top #(.BW(8), .CYC_US(1)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.step_tick(step_tick), .accel_active(accel), .duty_full(duty_full),
		.back_voltage(back_voltage), .averaged_back_voltage(averaged_back_voltage),
		.thermal_shutdown_flag(thermal), .undervoltage_flag(uv), .coil_fault_flag(coil),
		.step_pulse(step_pulse), .step_dir(step_dir), .motion_busy(motion_busy),
		.stall_out(stall_out));
	msd_motor_model motor_u (.hclk(hclk), .hresetn(hresetn),
		.bv_set(bv), .av_set(av), .step_tick(step_tick), .back_voltage(back_voltage),
		.averaged_back_voltage(averaged_back_voltage));

	// ==========================================================
	// Clock and watchdog
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// Steps and their direction are counted on the falling edge, away from the launch.
	always @(negedge hclk) begin
		if (step_pulse === 1'b1) begin
			n_steps++;
		end
		if (step_pulse === 1'b1 && step_dir === 1'b1) begin
			n_up++;
		end
	end
	// A hang anywhere ends the run through the normal closing path.
	initial begin
		repeat (40000) @(posedge hclk);
		bad_count++;
		wrap_up();
	end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One single word transfer; entered just after a rising edge.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge hclk);
		while (motion_busy !== 1'b0 && n < 5000) begin
			@(posedge hclk);
			n++;
		end
		// A motion that never ends counts against the run.
		if (motion_busy !== 1'b0) begin
			bad_count++;
		end
	endtask : wait_idle
	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
	endtask : do_reset
	task automatic wrap_up();
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// ==========================================================
	// Main sequence, in the host order from power-on.
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, duty_full, thermal, uv, coil, accel} = '0;
		bv = 8'h28;
		av = 8'h28;
		do_reset();
		bus(0, OFS_STAT1, 32'h0, q);
		chk(q & 32'h7ff, 32'h100);
		bus(0, OFS_POS, 32'h0, q);
		chk(q & 32'hffff, 32'h0);
		bus(1, OFS_MOTOR, 32'h0, q);
		bus(1, OFS_DET, 32'h00e0_f2e2, q);
		bus(0, OFS_DET, 32'h0, q);
		chk(q, 32'h00e0_f2e2);
		bus(1, 8'h20, 32'hffff_ffff, q);
		bus(0, 8'h20, 32'h0, q);
		chk(q, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		// A hot, starved or miswired device refuses motion and reports the fault.
		for (int k = 0; k < 3; k++) begin
			{coil, uv, thermal} <= 3'(1 << k);
			bus(1, OFS_TARGET, 32'h3, q);
			repeat (4) @(posedge hclk);
			chk({31'h0, motion_busy}, 32'h0);
			bus(0, OFS_STAT1, 32'h0, q);
			chk(q & 32'h7ff, 32'(32'h20 << k));
		end
		{coil, uv, thermal} <= 3'h0;
		bus(1, OFS_REF, 32'h0006_0002, q);
		wait_idle();
		chk(32'(n_steps), 32'd10);
		chk(32'(n_up), 32'd6);
		bus(0, OFS_POS, 32'h0, q);
		chk(q & 32'hffff, 32'h0);
		for (int i = 0; i < NC; i++) begin
			bus(1, OFS_DET, c_det[i], q);
			bv <= c_back[i];
			duty_full <= c_duty[i];
			bus(1, OFS_TARGET, 32'(4 * (i + 1)), q);
			wait_idle();
			chk({31'h0, stall_out}, {31'h0, |c_exp[i][2:0]});
			if (c_exp[i] != 5'h00) begin
				bus(1, OFS_TARGET, 32'h100, q);
				repeat (4) @(posedge hclk);
				chk({31'h0, motion_busy}, 32'h0);
			end else begin
				bus(0, OFS_POS, 32'h0, q);
				chk(q & 32'hffff, 32'(4 * (i + 1)));
			end
			bus(0, OFS_STAT1, 32'h0, q);
			chk({27'h0, q[4:0]}, {27'h0, c_exp[i]});
			bus(0, OFS_STAT1, 32'h0, q);
			chk({27'h0, q[4:0]}, 32'h0);
		end
		// First target equal to the position reached locks the sequencer.
		bv <= 8'h28;
		bus(1, OFS_REF, 32'h0024_0002, q);
		repeat (4) @(posedge hclk);
		bus(0, OFS_STAT1, 32'h0, q);
		chk({31'h0, q[9]}, 32'h1);
		do_reset();
		bus(0, OFS_STAT1, 32'h0, q);
		chk(q & 32'h7ff, 32'h100);
		// Fast chopper rate with code 2 still samples inside a step; blanking hides
		// the first three steps after acceleration, so a three-step move stays clean.
		bus(1, OFS_MOTOR, 32'h40, q);
		bus(1, OFS_DET, 32'h0040_0260, q);
		bv <= 8'h25;
		duty_full <= 1'b0;
		accel <= 1'b1;
		repeat (2) @(posedge hclk);
		accel <= 1'b0;
		bus(1, OFS_TARGET, 32'h3, q);
		wait_idle();
		bus(0, OFS_POS, 32'h0, q);
		chk(q & 32'hffff, 32'h3);
		bus(0, OFS_STAT1, 32'h0, q);
		chk({27'h0, q[4:0]}, 32'h0);
		bus(1, OFS_TARGET, 32'h8, q);
		wait_idle();
		bus(0, OFS_STAT1, 32'h0, q);
		chk({27'h0, q[4:0]}, 32'h19);
		wrap_up();
	end
endmodule : msd_stall_top_bench
